// ### hw/atu_pkg.sv
// Shared constants for the acquisition trigger unit
package atu_pkg;
   // ==========================================================
   // Sizes
   localparam int CH_N    = 16;
   localparam int SPAN    = 256;
   localparam int HIST_AW = 8;

   // ==========================================================
   // Timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int TRIG_PULSE_MS = 10;
   localparam int TRIG_PULSE_CYC = (CLK_HZ / 1000) * TRIG_PULSE_MS;

   // ==========================================================
   // Register byte offsets, and the history page matched on address bits 11:10
   localparam logic [11:0] OFF_CTRL   = 12'h000;
   localparam logic [11:0] OFF_PRETRG = 12'h004;
   localparam logic [11:0] OFF_FILTER = 12'h008;
   localparam logic [11:0] OFF_CHSEL  = 12'h00C;
   localparam logic [11:0] OFF_WINSEL = 12'h010;
   localparam logic [11:0] OFF_EVTYPE = 12'h014;
   localparam logic [11:0] OFF_STATUS = 12'h018;
   localparam logic [11:0] OFF_MASK   = 12'h01C;
   localparam logic [11:0] OFF_STATE  = 12'h020;
   localparam logic [1:0]  HIST_PAGE  = 2'h1;

   // ==========================================================
   // Fields and limits
   localparam int CTRL_START   = 0;
   localparam int CTRL_STOP    = 1;
   localparam int CTRL_OP_LSB  = 2;
   localparam int CTRL_TM_LSB  = 4;
   localparam int ST_TRIG      = 0;
   localparam int ST_DONE      = 1;
   localparam int ST_REFUSED   = 2;
   localparam logic [6:0]  PRETRG_MAX = 7'h64;
   localparam logic [6:0]  PRETRG_RST = 7'h00;
   localparam logic [15:0] FILTER_MIN = 16'h0001;
   localparam logic [15:0] FILTER_MAX = 16'hFFFE;

   // ==========================================================
   // Modes and states
   typedef enum logic [1:0] {
      TM_OFF = 2'h0, TM_OR = 2'h1, TM_AND = 2'h2, TM_WIN = 2'h3
   } atu_tmode_type;

   typedef enum logic [1:0] {
      OP_ONCE = 2'h0, OP_REPEAT = 2'h1, OP_ENDLESS = 2'h2
   } atu_op_type;

   typedef enum logic [4:0] {
      S_IDLE = 5'b00001,
      S_PRE  = 5'b00010,
      S_WAIT = 5'b00100,
      S_POST = 5'b01000,
      S_REC  = 5'b10000
   } atu_state_type;
endpackage : atu_pkg

// ### hw/atu_sync3.sv
// Three-stage pin synchroniser, change taken when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module atu_sync3 #(
   parameter int W = 1
) (
   input  wire logic         clock_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   wire  [W-1:0] agree = ~(s2 ^ s3);

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s1  <= '0;
         s2  <= '0;
         s3  <= '0;
         q_o <= '0;
      end else begin
         s1  <= d_i;
         s2  <= s1;
         s3  <= s2;
         q_o <= (s3 & agree) | (q_o & ~agree);
      end
   end
endmodule : atu_sync3
`default_nettype wire

// ### hw/atu_trigger.sv
// Acquisition trigger unit: sources, modes, filter, history and trigger pulse
`timescale 1ns/100ps
`default_nettype none
module atu_trigger
   import atu_pkg::*;
#(
   parameter int PULSE_CYCLES = TRIG_PULSE_CYC
) (
   input  wire logic            clock_i,
   input  wire logic            rst_i,
   input  wire logic            psel_i,
   input  wire logic            penable_i,
   input  wire logic            pwrite_i,
   input  wire logic [11:0]     paddr_i,
   input  wire logic [31:0]     pwdata_i,
   output logic      [31:0]     prdata_o,
   output logic                 pready_o,
   output logic                 pslverr_o,
   input  wire logic [CH_N-1:0] chan_cond_i,
   input  wire logic [CH_N-1:0] chan_band_i,
   input  wire logic            manual_trig_i,
   input  wire logic            ext_trig_i,
   input  wire logic [15:0]     sample_i,
   output logic                 trig_out_n_o,
   output logic                 irq_o
);
   // ==========================================================
   // Pin synchronisers
   wire  [2*CH_N+1:0] pins_raw = {ext_trig_i, manual_trig_i,
                                  chan_band_i, chan_cond_i};
   logic [2*CH_N+1:0] pins_q;

   atu_sync3 #(.W(2*CH_N+2)) u_sync (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .d_i     (pins_raw),
      .q_o     (pins_q)
   );

   wire [CH_N-1:0] cond   = pins_q[CH_N-1:0];
   wire [CH_N-1:0] band   = pins_q[2*CH_N-1:CH_N];
   wire            manual = pins_q[2*CH_N];
   wire            ext    = pins_q[2*CH_N+1];

   // ==========================================================
   // Registers
   atu_tmode_type    tmode;
   atu_op_type       opmode;
   logic [6:0]       pretrg;
   logic [15:0]      filt_len;
   logic [CH_N-1:0]  chsel;
   logic [CH_N-1:0]  winsel;
   logic [CH_N-1:0]  evtype;
   logic [2:0]       status;
   logic [2:0]       mask;
   atu_state_type    state;
   atu_state_type    next_state;
   logic [15:0]      hist [SPAN];
   logic [HIST_AW-1:0] wptr;
   logic [HIST_AW-1:0] trig_addr;
   logic [8:0]       phase_cnt;
   logic [15:0]      run_cnt;
   logic             qual_d;
   logic             manual_d;
   logic             ext_d;
   logic [CH_N-1:0]  band_ref;
   logic [16:0]      pulse_cnt;

   // ==========================================================
   // Bus decode
   wire setup   = psel_i & ~penable_i;
   wire access  = psel_i & penable_i & pready_o;
   wire wr      = access & pwrite_i;
   wire rd_done = access & ~pwrite_i;
   wire [11:0] adr = {paddr_i[11:2], 2'b00};

   wire sel_ctrl   = adr == OFF_CTRL;
   wire sel_pretrg = adr == OFF_PRETRG;
   wire sel_filter = adr == OFF_FILTER;
   wire sel_chsel  = adr == OFF_CHSEL;
   wire sel_winsel = adr == OFF_WINSEL;
   wire sel_evtype = adr == OFF_EVTYPE;
   wire sel_status = adr == OFF_STATUS;
   wire sel_mask   = adr == OFF_MASK;
   wire sel_state  = adr == OFF_STATE;
   wire sel_hist   = paddr_i[11:10] == HIST_PAGE;
   wire hit = sel_ctrl | sel_pretrg | sel_filter | sel_chsel | sel_winsel
            | sel_evtype | sel_status | sel_mask | sel_state | sel_hist;

   wire start_w = wr & sel_ctrl & pwdata_i[CTRL_START];
   wire stop_w  = wr & sel_ctrl & pwdata_i[CTRL_STOP];

   wire [31:0] rd_ctrl  = {26'h0, tmode, opmode, 2'b00};
   wire [31:0] rd_state = {16'h0, trig_addr, 3'h0, state};
   wire [31:0] rd_mux =
        sel_ctrl   ? rd_ctrl :
        sel_pretrg ? {25'h0, pretrg} :
        sel_filter ? {16'h0, filt_len} :
        sel_chsel  ? {16'h0, chsel} :
        sel_winsel ? {16'h0, winsel} :
        sel_evtype ? {16'h0, evtype} :
        sel_status ? {29'h0, status} :
        sel_mask   ? {29'h0, mask} :
        sel_state  ? rd_state :
        sel_hist   ? {16'h0, hist[paddr_i[9:2]]} : 32'h0000_0000;

   // Writes clamp out-of-range values rather than refusing the word
   wire [6:0]  pct_w  = pwdata_i[6:0] > PRETRG_MAX ? PRETRG_MAX
                                                   : pwdata_i[6:0];
   wire [15:0] flt_w  = pwdata_i[15:0] < FILTER_MIN ? FILTER_MIN :
                        pwdata_i[15:0] > FILTER_MAX ? FILTER_MAX :
                        pwdata_i[15:0];
   wire [CH_N-1:0] ev_new = sel_evtype ? pwdata_i[CH_N-1:0] : evtype;
   wire [CH_N-1:0] win_w  = sel_winsel ? pwdata_i[CH_N-1:0] : winsel;
   wire refuse = wr & (sel_winsel | sel_evtype) & |(win_w & ev_new);

   // ==========================================================
   // Trigger qualification
   wire raw_or  = |(cond & chsel);
   wire raw_and = (chsel != '0) & (&(cond | ~chsel));
   wire raw_win = |(winsel & (band ^ band_ref));
   wire raw = (tmode == TM_OR)  ? raw_or  :
              (tmode == TM_AND) ? raw_and :
              (tmode == TM_WIN) ? raw_win : 1'b0;
   wire qual = raw & (run_cnt >= filt_len - 16'h0001);
   // Channel trigger fires once per qualification; it must lapse first
   wire chan_trig = qual & ~qual_d;
   wire man_rise  = manual & ~manual_d;
   wire ext_rise  = ext & ~ext_d;
   wire armed     = (state == S_WAIT) | (state == S_REC);
   wire trig_evt  = armed & (chan_trig | man_rise | ext_rise);

   // ==========================================================
   // Capture sequence
   wire [15:0] pre_prod = 16'(pretrg) * 16'(SPAN);
   wire [8:0]  pre_len  = 9'(pre_prod / 16'd100);
   wire [8:0]  post_len = 9'(SPAN) - pre_len;
   wire        post_end = (state == S_POST) & (phase_cnt >= post_len);
   wire [2:0]  set_bits = {refuse, post_end, trig_evt};

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: if (start_w)
            next_state = (opmode == OP_ENDLESS) ? S_REC : S_PRE;
         S_PRE:  if (phase_cnt >= pre_len) next_state = S_WAIT;
         S_WAIT: if (trig_evt) next_state = S_POST;
         S_POST: if (post_end)
            next_state = (opmode == OP_REPEAT) ? S_PRE : S_IDLE;
         S_REC:  next_state = S_REC;
         default: next_state = S_IDLE;
      endcase
      if (stop_w) next_state = S_IDLE;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state     <= S_IDLE;
         phase_cnt <= '0;
         wptr      <= '0;
         trig_addr <= '0;
      end else begin
         state     <= next_state;
         phase_cnt <= (next_state != state) ? 9'h000 : phase_cnt + 9'h001;
         if (state != S_IDLE) wptr <= wptr + 8'h01;
         if (trig_evt) trig_addr <= wptr;
      end
   end

   // History has no reset; it only ever holds captured samples
   always_ff @(posedge clock_i) begin
      if (state != S_IDLE) hist[wptr] <= sample_i;
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         run_cnt  <= '0;
         qual_d   <= 1'b0;
         manual_d <= 1'b0;
         ext_d    <= 1'b0;
         band_ref <= '0;
      end else begin
         run_cnt  <= !raw ? 16'h0000 :
                     (run_cnt == 16'hFFFF) ? run_cnt : run_cnt + 16'h0001;
         qual_d   <= qual;
         manual_d <= manual;
         ext_d    <= ext;
         // Reference band state taken at arming and after each crossing
         if (start_w | chan_trig) band_ref <= band;
      end
   end

   // ==========================================================
   // Trigger output pulse, restarted by a trigger inside a pulse
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         pulse_cnt    <= '0;
         trig_out_n_o <= 1'b1;
      end else begin
         if (trig_evt) pulse_cnt <= 17'(PULSE_CYCLES);
         else if (pulse_cnt != '0) pulse_cnt <= pulse_cnt - 17'h0_0001;
         trig_out_n_o <= ~(trig_evt | (pulse_cnt > 17'h0_0001));
      end
   end

   // ==========================================================
   // Register writes
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         tmode    <= TM_OFF;
         opmode   <= OP_ONCE;
         pretrg   <= PRETRG_RST;
         filt_len <= FILTER_MIN;
         chsel    <= '0;
         winsel   <= '0;
         evtype   <= '0;
         mask     <= '0;
      end else if (wr) begin
         if (sel_ctrl) begin
            tmode  <= atu_tmode_type'(pwdata_i[CTRL_TM_LSB +: 2]);
            opmode <= (pwdata_i[CTRL_OP_LSB +: 2] == 2'h3) ? OP_ONCE
                      : atu_op_type'(pwdata_i[CTRL_OP_LSB +: 2]);
         end
         if (sel_pretrg) pretrg   <= pct_w;
         if (sel_filter) filt_len <= flt_w;
         if (sel_chsel)  chsel    <= pwdata_i[CH_N-1:0];
         if (sel_evtype) evtype   <= ev_new;
         if (sel_winsel | sel_evtype)
            winsel <= win_w & ~ev_new;
         if (sel_mask)   mask     <= pwdata_i[2:0];
      end
   end

   // ==========================================================
   // Status, interrupt and bus answer
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         status    <= '0;
         irq_o     <= 1'b0;
         prdata_o  <= '0;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         // A new event in the clearing read's cycle stays set; only the
         // bits that the read reported are cleared, so none is lost
         if (rd_done & sel_status)
            status <= (status & ~prdata_o[2:0]) | set_bits;
         else status <= status | set_bits;
         irq_o     <= |(status & mask);
         pready_o  <= setup;
         pslverr_o <= setup & ~hit;
         if (setup) prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
      end
   end
endmodule : atu_trigger
`default_nettype wire

// ### verif/atu_chan_model.sv
// Model of the channel comparators and external trigger source
`timescale 1ns/100ps
`default_nettype none
module atu_chan_model (
   input  wire logic        clock_i,
   input  wire logic        slow_i,
   input  wire logic [15:0] cond_req_i,
   input  wire logic        ext_req_i,
   input  wire logic [15:0] band_req_i,
   output logic      [15:0] chan_cond_o,
   output logic      [15:0] chan_band_o,
   output logic             ext_trig_o
);
   logic [15:0] lag_cond;
   logic        lag_ext;
   initial begin
      chan_cond_o = 16'h0000;
      ext_trig_o  = 1'b0;
   end
   // Slow mode adds a cycle to chan_cond_o and ext_trig_o, like a comparator with a longer settle time
   always @(posedge clock_i) begin
      lag_cond    <= cond_req_i;
      lag_ext     <= ext_req_i;
      chan_cond_o <= slow_i ? lag_cond : cond_req_i;
      chan_band_o <= band_req_i;
      ext_trig_o  <= slow_i ? lag_ext : ext_req_i;
   end
endmodule : atu_chan_model
`default_nettype wire

// ### verif/atu_trigger_sva.sv
// Port-level checker for the acquisition trigger unit
`timescale 1ns/100ps
`default_nettype none
module atu_trigger_sva
   import atu_pkg::*;
#(
   parameter int PULSE_CYCLES = 20
) (
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        trig_out_n_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // =========================================================
   // Helper: cycles spent low in the current pulse
   logic [31:0] low_cnt;
   always_ff @(posedge clock_i) begin
      low_cnt <= (rst_i || trig_out_n_o) ? 32'h0000_0000 : low_cnt + 1;
   end
   // =========================================================
   // Sequences and properties
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_rd(logic [11:0] a);
      psel_i && penable_i && pready_o && !pwrite_i && paddr_i == a;
   endsequence
   property p_answer; s_setup |=> pready_o; endproperty
   property p_one; pready_o |=> !pready_o; endproperty
   property p_err; pslverr_o |-> pready_o; endproperty
   property p_unmap;
      psel_i && penable_i && pready_o
      && paddr_i inside {[12'h024:12'h3FF]} |-> pslverr_o;
   endproperty
   property p_errdata; pslverr_o && !pwrite_i |-> prdata_o == 0; endproperty
   property p_pre; s_rd(OFF_PRETRG) |-> prdata_o <= 32'd100; endproperty
   property p_filt;
      s_rd(OFF_FILTER) |-> prdata_o inside {[32'h1:32'h0000_FFFE]};
   endproperty
   property p_state; s_rd(OFF_STATE) |-> $onehot(prdata_o[4:0]); endproperty
   property p_plen; $fell(trig_out_n_o) |-> !trig_out_n_o[*8]; endproperty
   property p_pend;
      $rose(trig_out_n_o) |-> low_cnt >= PULSE_CYCLES;
   endproperty
   a_answer:  assert property (p_answer) else $error("no ready after setup");
   a_one:     assert property (p_one) else $error("ready held too long");
   a_err:     assert property (p_err) else $error("error without ready");
   a_unmap:   assert property (p_unmap) else $error("unmapped not refused");
   a_errdata: assert property (p_errdata) else $error("refused read not 0");
   a_pre:     assert property (p_pre) else $error("pretrig too big");
   a_filt:    assert property (p_filt) else $error("filter range");
   a_state:   assert property (p_state) else $error("state not one-hot");
   a_plen:    assert property (p_plen) else $error("pulse short");
   a_pend:    assert property (p_pend) else $error("pulse ends");
endmodule : atu_trigger_sva
`default_nettype wire

// ### verif/atu_trigger_tb.sv
// Self-checking testbench for the acquisition trigger unit
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   num_errors++; $display("Error at %0t: got %h expected %h", \
   $time, (g), (e)); end end
module atu_trigger_tb;
   import atu_pkg::*;
   localparam int PULSE = 20;
   logic clock_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata_o;
   logic pready_o, pslverr_o, trig_out_n_o, irq_o, ext_trig, slow = 0;
   logic manual_trig = 0, ext_req = 0;
   logic [15:0] band_req = 16'hFFFF;
   logic [15:0] cond_req = 0, chan_cond, chan_band, sample = 0;
   int num_errors = 0;
   int samples_checked = 0;
   always #50 clock_i = ~clock_i;
   always @(posedge clock_i) sample <= sample + 16'h0001;
   atu_trigger #(.PULSE_CYCLES(PULSE)) atu_trigger_i (.clock_i, .rst_i,
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o, .pready_o,
      .pslverr_o, .chan_cond_i(chan_cond), .chan_band_i(chan_band),
      .manual_trig_i(manual_trig), .ext_trig_i(ext_trig),
      .sample_i(sample), .trig_out_n_o, .irq_o);
   atu_chan_model atu_chan_model_i (.clock_i, .slow_i(slow),
      .cond_req_i(cond_req), .ext_req_i(ext_req), .band_req_i(band_req),
      .chan_cond_o(chan_cond),
      .chan_band_o(chan_band), .ext_trig_o(ext_trig));
   // =========================================================
   // Shared tasks
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", samples_checked,
               num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int n;
      @(posedge clock_i);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock_i);
      penable <= 1;
      n = 0;
      do begin @(posedge clock_i); n++; end
      while (pready_o !== 1'b1 && n < 16);
      if (n >= 16) begin num_errors++; finish_test(); end
      r = prdata_o;
      e = pslverr_o;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r; logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      logic [31:0] r; logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      `CHK(r, x)
   endtask : rdc
   task automatic arm(input logic [1:0] tm);
      wr(OFF_CTRL, {26'h0, tm, 4'h2});
      wr(OFF_CTRL, {26'h0, tm, 4'h1});
      repeat (4) @(posedge clock_i);
   endtask : arm
   task automatic expect_trig(input bit x);
      int n; int low; bit seen;
      seen = 0; low = 0;
      for (n = 0; n < 30 && !seen; n++) begin
         @(posedge clock_i); seen = (trig_out_n_o === 1'b0);
      end
      `CHK(seen, x)
      if (seen) begin
         low = 1;
         for (n = 0; n < 200 && trig_out_n_o === 1'b0; n++) begin
            @(posedge clock_i); if (trig_out_n_o === 1'b0) low++;
         end
         `CHK(low, PULSE)
      end
   endtask : expect_trig
   // =========================================================
   // Scenarios
   task automatic t_reset();
      rdc(OFF_CTRL, 0); rdc(OFF_PRETRG, 0); rdc(OFF_FILTER, 1);
      rdc(OFF_STATUS, 0); rdc(OFF_MASK, 0); rdc(OFF_STATE, 1);
   endtask : t_reset
   task automatic t_regs();
      logic [31:0] r; logic e;
      wr(OFF_PRETRG, 101); rdc(OFF_PRETRG, 100);
      wr(OFF_PRETRG, 0); wr(OFF_FILTER, 0); rdc(OFF_FILTER, 1);
      wr(OFF_FILTER, 32'h0000_FFFF);
      rdc(OFF_FILTER, 32'h0000_FFFE);
      apb(1'b0, 12'h024, 0, r, e);
      `CHK(e, 1'b1)
      `CHK(r, 32'h0000_0000)
   endtask : t_regs
   task automatic t_win();
      wr(OFF_EVTYPE, 1); wr(OFF_WINSEL, 3); rdc(OFF_WINSEL, 2);
      rdc(OFF_STATUS, 4);
   endtask : t_win
   task automatic t_off();
      wr(OFF_FILTER, 1); wr(OFF_MASK, 1); wr(OFF_CHSEL, 1); arm(TM_OFF);
      cond_req <= 1; expect_trig(0);
      ext_req <= 1; expect_trig(1);
      `CHK(irq_o, 1'b1)
      rdc(OFF_STATUS, 1);
      repeat (2) @(posedge clock_i);
      `CHK(irq_o, 1'b0)
      cond_req <= 0; ext_req <= 0;
      arm(TM_OFF); manual_trig <= 1; expect_trig(1);
      manual_trig <= 0;
   endtask : t_off
   task automatic t_or();
      slow <= 1; wr(OFF_FILTER, 4); wr(OFF_CHSEL, 3); arm(TM_OR);
      cond_req <= 2; repeat (2) @(posedge clock_i);
      cond_req <= 0; expect_trig(0);
      cond_req <= 2; expect_trig(1);
      cond_req <= 0; slow <= 0;
   endtask : t_or
   task automatic t_and();
      arm(TM_AND); cond_req <= 1; expect_trig(0);
      cond_req <= 3; expect_trig(1);
      cond_req <= 0;
   endtask : t_and
   task automatic t_wtrig();
      repeat (300) @(posedge clock_i);
      rdc(OFF_STATUS, 3);
      wr(OFF_EVTYPE, 0); wr(OFF_WINSEL, 1); arm(TM_WIN);
      band_req <= 16'hFFFE; expect_trig(1);
      expect_trig(0);
   endtask : t_wtrig
   initial begin
      repeat (20000) @(posedge clock_i);
      num_errors++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge clock_i);
      rst_i <= 0;
      t_reset(); t_regs(); t_win(); t_off(); t_or(); t_and(); t_wtrig();
      finish_test();
   end
endmodule : atu_trigger_tb
bind atu_trigger atu_trigger_sva #(.PULSE_CYCLES(PULSE_CYCLES))
   atu_trigger_sva_i (.clock_i, .rst_i, .psel_i, .penable_i, .pwrite_i,
   .paddr_i, .prdata_o, .pready_o, .pslverr_o, .trig_out_n_o);
`default_nettype wire
